// [design/psb_map.vh]
// Constants for the pipelined burst SRAM access block.
// What this block does
// (R1) Write qualifier: global write, or master plus lane
// (R2) Read when no write qualifier is active
// (R3) Output enable acts asynchronously on data pins
// (R4) Processor strobe starts a read cycle, never a write, when the chip is selected and awake
// (R5) Writes only after processor start or controller start
// (R6) Master raises output enable before writes
// (R7) Output enable masked internally during write cycles
// (R8) Read drives when enabled, floats when deselected
// (R9) Continue burst write at next burst address
// (R10) Suspend read re-reads current burst address
// (R11) Suspend write rewrites current burst address
// (R12) Byte write selects lanes; global writes all
// (R13) Two-bit wraparound counter, interleaved or linear order
// (R14) Unselected byte lanes stay unchanged
// (R15) Sleep entered or left on the fourth clock after the sleep pin changes
// (R16) Data path is four nine-bit byte lanes
`ifndef PSB_MAP_VH
`define PSB_MAP_VH
`define PSB_ADDR_W 17
`define PSB_LANES 4
`define PSB_LANE_W 9
`define PSB_DATA_W 36
`define PSB_BURST_W 2
`define PSB_BURST_RST 2'h0
`define PSB_SYNC_RST 3'h0
`define PSB_OUT_RST 36'h000000000
`endif

// [design/psb_sram.v]
// Pipelined burst SRAM core with cycle decode, burst counter and data path control.
`timescale 1ns/1ps
`default_nettype none
`include "psb_map.vh"

module psb_sram #(
   parameter ADDR_W = `PSB_ADDR_W,
   parameter LANES = `PSB_LANES,
   parameter LANE_W = `PSB_LANE_W
) (
   input wire clock,
   input wire rst,
   input wire [ADDR_W-1:0] addr,
   input wire processor_addr_strobe_n,
   input wire controller_addr_strobe_n,
   input wire burst_step_n,
   input wire global_write_n,
   input wire byte_write_master_n,
   input wire [LANES-1:0] byte_lane_write_n,
   input wire chip_sel_first_n,
   input wire chip_sel_second,
   input wire chip_sel_third_n,
   input wire sleep_request,
   input wire burst_order_linear,
   input wire output_drive_n,
   input wire [LANES*LANE_W-1:0] dq_in,
   output wire [LANES*LANE_W-1:0] dq_out,
   output wire dq_oe
);

   localparam DATA_W = LANES * LANE_W;
   localparam DEPTH = 1 << ADDR_W;

   // ************************************************************
   // Sleep synchroniser
   // ************************************************************
   // The sleep pin is asynchronous; stage one feeds stage two only.
   reg [2:0] sleep_sync_ff;
   reg sleep_ff;
   always @(posedge clock) begin
      if (rst) begin
         sleep_sync_ff <= `PSB_SYNC_RST;
         sleep_ff <= 1'b0;
      end else begin
         sleep_sync_ff <= {sleep_sync_ff[1:0], sleep_request};
         if (sleep_sync_ff[1] == sleep_sync_ff[2]) begin
            sleep_ff <= sleep_sync_ff[2]; // [R15]
         end
      end
   end

   // ************************************************************
   // Cycle decode
   // ************************************************************
   localparam CYC_IDLE = 3'h0;
   localparam CYC_DESELECT = 3'h1;
   localparam CYC_PROC_READ = 3'h2;
   localparam CYC_CTRL_READ = 3'h3;
   localparam CYC_CTRL_WRITE = 3'h4;
   localparam CYC_BURST_READ = 3'h5;
   localparam CYC_BURST_WRITE = 3'h6;
   localparam CYC_ASLEEP = 3'h7;

   wire any_lane_n = &byte_lane_write_n;
   wire write_q = ~global_write_n | (~byte_write_master_n & ~any_lane_n); // [R1]
   wire read_q = global_write_n & (byte_write_master_n | any_lane_n); // [R2]
   wire selected = ~chip_sel_first_n & chip_sel_second & ~chip_sel_third_n;
   // A processor strobe is ignored while the first select is high.
   wire proc_start = ~processor_addr_strobe_n & ~chip_sel_first_n;
   wire ctrl_start = processor_addr_strobe_n & ~controller_addr_strobe_n;
   wire any_start = proc_start | ctrl_start;
   wire burst_cyc = ~any_start & controller_addr_strobe_n;

   // The order of the tests is the priority: sleep first, then a start that
   // is not meant for us, then the processor strobe, which never writes.
   reg [2:0] cyc_kind;
   always @* begin
      cyc_kind = CYC_IDLE;
      if (sleep_ff) begin
         cyc_kind = CYC_ASLEEP; // [R15]
      end else if (any_start & ~selected) begin
         cyc_kind = CYC_DESELECT; // [R8]
      end else if (proc_start) begin
         cyc_kind = CYC_PROC_READ; // [R4]
      end else if (ctrl_start & write_q) begin
         cyc_kind = CYC_CTRL_WRITE; // [R5]
      end else if (ctrl_start & read_q) begin
         cyc_kind = CYC_CTRL_READ; // [R2]
      end else if (burst_cyc & write_q) begin
         cyc_kind = CYC_BURST_WRITE; // [R9] [R11]
      end else if (burst_cyc & read_q) begin
         cyc_kind = CYC_BURST_READ; // [R10]
      end
   end

   // One cycle does at most one access; the class is turned into strobes here.
   reg do_read;
   reg do_write;
   reg load_base;
   reg step_burst;
   always @* begin
      do_read = 1'h0;
      do_write = 1'h0;
      load_base = 1'h0;
      step_burst = 1'h0;
      case (cyc_kind)
         CYC_PROC_READ: begin
            do_read = 1'h1; // [R4]
            load_base = 1'h1;
         end
         CYC_CTRL_READ: begin
            do_read = 1'h1; // [R2]
            load_base = 1'h1;
         end
         CYC_CTRL_WRITE: begin
            do_write = 1'h1; // [R5]
            load_base = 1'h1;
         end
         CYC_BURST_READ: begin
            do_read = 1'h1; // [R10]
            step_burst = ~burst_step_n; // [R13]
         end
         CYC_BURST_WRITE: begin
            do_write = 1'h1; // [R9] [R11]
            step_burst = ~burst_step_n; // [R13]
         end
         default: begin
            // Deselect, sleep and idle cycles leave the burst state alone.
            do_read = 1'h0;
            do_write = 1'h0;
         end
      endcase
   end

   // ************************************************************
   // Burst address
   // ************************************************************
   reg [ADDR_W-1:0] base_ff;
   reg [`PSB_BURST_W-1:0] count_ff;
   reg [`PSB_BURST_W-1:0] nxt_count;
   reg [ADDR_W-1:0] nxt_base;
   reg [`PSB_BURST_W-1:0] low_bits;
   reg [ADDR_W-1:0] use_addr;

   always @* begin
      nxt_base = base_ff;
      nxt_count = count_ff;
      if (load_base) begin
         nxt_base = addr;
         nxt_count = `PSB_BURST_RST;
      end else if (step_burst) begin
         nxt_count = count_ff + 2'h1; // [R13]
      end
      if (burst_order_linear) begin
         low_bits = nxt_base[`PSB_BURST_W-1:0] + nxt_count; // [R13]
      end else begin
         low_bits = nxt_base[`PSB_BURST_W-1:0] ^ nxt_count; // [R13]
      end
      use_addr = {nxt_base[ADDR_W-1:`PSB_BURST_W], low_bits};
   end

   always @(posedge clock) begin
      if (rst) begin
         base_ff <= {ADDR_W{1'b0}};
         count_ff <= `PSB_BURST_RST;
      end else begin
         base_ff <= nxt_base;
         count_ff <= nxt_count;
      end
   end

   // ************************************************************
   // Storage and byte lanes
   // ************************************************************
   reg [DATA_W-1:0] mem [0:DEPTH-1];
   wire [DATA_W-1:0] old_word = mem[use_addr];
   wire [DATA_W-1:0] merged;
   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1) begin : g_lane
         // Global write takes every lane; otherwise only low lane enables.
         wire lane_wr = ~global_write_n | ~byte_lane_write_n[g]; // [R12] [R16]
         assign merged[g*LANE_W +: LANE_W] = lane_wr ? dq_in[g*LANE_W +: LANE_W]
            : old_word[g*LANE_W +: LANE_W]; // [R14]
      end
   endgenerate

   reg [DATA_W-1:0] out_ff;
   reg rd_vld_ff;
   always @(posedge clock) begin
      if (do_write) begin
         mem[use_addr] <= merged; // [R12]
      end
   end

   // Read data leaves through an output register, one clock after the cycle.
   always @(posedge clock) begin
      if (rst) begin
         out_ff <= `PSB_OUT_RST;
         rd_vld_ff <= 1'b0;
      end else begin
         rd_vld_ff <= do_read; // [R8]
         if (do_read) begin
            out_ff <= old_word;
         end
      end
   end

   // ************************************************************
   // Output drive
   // ************************************************************
   // The enable pin is never sampled, and a write seen at the inputs
   // forces the pins off even if the master forgot to raise the enable.
   assign dq_oe = rd_vld_ff & ~output_drive_n & ~do_write & ~sleep_ff; // [R3] [R7] [R8]
   assign dq_out = out_ff;

endmodule // psb_sram
`default_nettype wire

// [verification/psb_chk_sva.sv]
// Assertion checker for the burst SRAM access block.
`timescale 1ns/1ps
`default_nettype none
module psb_chk (input wire clock, rst, processor_addr_strobe_n, controller_addr_strobe_n,
   global_write_n, byte_write_master_n, chip_sel_first_n, chip_sel_second, chip_sel_third_n,
   output_drive_n, dq_oe, input wire [3:0] byte_lane_write_n);
   wire sel = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
   wire wq = !global_write_n || (!byte_write_master_n && !(&byte_lane_write_n));
   wire ps = !processor_addr_strobe_n && !chip_sel_first_n;
   wire cs = processor_addr_strobe_n && !controller_addr_strobe_n;
   wire bu = !ps && controller_addr_strobe_n;
   wire rd = (ps && sel) || (((cs && sel) || bu) && !wq);
   wire wr = ((cs && sel) || bu) && wq;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_oe_en; output_drive_n |-> !dq_oe; endproperty
   a_oe_en: assert property (p_oe_en) else $error("drive with enable off");
   property p_wr_mask; wr |-> !dq_oe; endproperty
   a_wr_mask: assert property (p_wr_mask) else $error("drive in write");
   property p_proc_rd; ps && sel ##1 !output_drive_n && !wr |-> dq_oe; endproperty
   a_proc_rd: assert property (p_proc_rd) else $error("no read on proc start");
   property p_rd; rd ##1 !output_drive_n && !wr |-> dq_oe; endproperty
   a_rd: assert property (p_rd) else $error("read not driven");
   property p_desel; (ps || cs) && !sel |=> !dq_oe; endproperty
   a_desel: assert property (p_desel) else $error("drive after deselect");
   property p_src; dq_oe |-> $past(rd); endproperty
   a_src: assert property (p_src) else $error("drive without read");
   property p_ctrl_wr; cs && sel && wq |=> !dq_oe; endproperty
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("write read back");
   property p_burst_wr; bu && wq |=> !dq_oe; endproperty
   a_burst_wr: assert property (p_burst_wr) else $error("burst write read");
endmodule // psb_chk
bind psb_sram psb_chk i_chk (.*);
`default_nettype wire

// [verification/psb_host.sv]
// Bus master model that issues cycles to the burst SRAM access block.
`timescale 1ns/1ps
`default_nettype none
module psb_host (input wire clock, output logic processor_addr_strobe_n,
   controller_addr_strobe_n, burst_step_n, chip_sel_first_n, chip_sel_second,
   chip_sel_third_n, global_write_n, byte_write_master_n, sleep_request, output_drive_n,
   output logic [3:0] byte_lane_write_n, output logic [16:0] addr, output logic [35:0] dq_in);
   logic [5:0] k_ff = 6'h2E, w_ff = 6'h3F;
   assign {processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n, chip_sel_first_n,
      chip_sel_second, chip_sel_third_n} = k_ff;
   assign {global_write_n, byte_write_master_n, byte_lane_write_n} = w_ff;
   initial begin
      sleep_request = 1'h0;
      addr = 17'h0;
      dq_in = 36'h0;
      output_drive_n = 1'h1;
   end
   task automatic cyc(input logic [5:0] k, w, input logic [16:0] a, input logic [35:0] d);
      @(posedge clock);
      k_ff <= k;
      w_ff <= w;
      addr <= a;
      dq_in <= d;
      // Enable goes off with every write so the shared data lines never contend.
      output_drive_n <= (k[5] || k[2]) && (!w[5] || (!w[4] && !(&w[3:0])));
   endtask
endmodule // psb_host
`default_nettype wire

// [verification/psb_sram_tb_top.sv]
// Self-checking bench for the burst SRAM access block.
`timescale 1ns/1ps
`default_nettype none
module psb_sram_tb_top;
   logic clock = 1'h0, rst = 1'h1, burst_order_linear = 1'h0, dq_oe, sleep_request;
   logic processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n, chip_sel_first_n;
   logic chip_sel_second, chip_sel_third_n, global_write_n, byte_write_master_n;
   logic output_drive_n;
   logic [3:0] byte_lane_write_n;
   logic [16:0] addr, a, b;
   logic [35:0] dq_in, dq_out, mem [int], q [$];
   logic [5:0] ds [3] = '{6'h2E, 6'h28, 6'h2B};
   logic [5:0] ws [4] = '{6'h32, 6'h16, 6'h3A, 6'h32};
   logic [5:0] rs [5] = '{6'h32, 6'h16, 6'h3A, 6'h1E, 6'h32};
   int n_errors = 0, num_checks = 0, t = 0, j = 0;
   always #2.5 clock = ~clock;
   psb_host i_host (.*);
   psb_sram i_dut (.*);
   task automatic chk(input logic [35:0] s, e);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %0t read data mismatch", $time);
      end
   endtask
   task automatic finish_test;
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // The model follows the burst address itself; reads expect what it last stored.
   task automatic op(input logic [5:0] k, w, input logic [16:0] a);
      logic [35:0] d;
      logic [16:0] x;
      logic ps, st;
      d = 36'({$urandom(), $urandom()});
      i_host.cyc(k, w, a, d);
      if (sleep_request) return;
      ps = !k[5] && !k[2];
      st = ps || (k[5] && !k[4]);
      if (st && k[2:0] == 3'h2) begin
         b = a;
         j = 0;
      end else if (!st && k[4] && !k[3]) j++;
      x = {b[16:2], burst_order_linear ? b[1:0] + 2'(j) : b[1:0] ^ 2'(j)};
      if (st ? k[2:0] != 3'h2 : !k[4]) return;
      if (!ps && (!w[5] || (!w[4] && !(&w[3:0])))) begin
         for (int l = 0; l < 4; l++) if (!w[5] || !w[l]) mem[x][9*l+:9] = d[9*l+:9];
      end else q.push_back(mem[x]);
   endtask
   always @(negedge clock) if (!rst && dq_oe === 1'h1) chk(dq_out, q.pop_front());
   always @(posedge clock) if (++t == 1000) begin
      n_errors++;
      finish_test();
   end
   initial begin
      void'($urandom(15615));
      repeat (2) @(posedge clock);
      rst <= 1'h0;
      for (int m = 0; m < 8; m++) begin
         burst_order_linear <= m[0];
         a = {15'($urandom()), m[2:1]};
         op(6'h2A, {1'h0, 5'($urandom())}, a);
         foreach (ws[i]) op(ws[i], 6'h1F, a);
         op(ds[m % 3], 6'h3F, a);
         op(6'h2A, {2'h2, 4'($urandom())}, a);
         op(6'h1A, 6'h00, a);
         foreach (rs[i]) op(rs[i], 6'h3F, a);
         op(ds[m % 3], 6'h3F, a);
      end
      // A write issued while asleep must not land; the read after waking shows the old word.
      @(posedge clock) i_host.sleep_request <= 1'h1;
      repeat (4) @(posedge clock);
      op(6'h2A, 6'h1F, a);
      op(6'h2E, 6'h3F, a);
      i_host.sleep_request <= 1'h0;
      repeat (4) @(posedge clock);
      op(6'h1A, 6'h3F, a);
      op(6'h2E, 6'h3F, a);
      repeat (2) @(negedge clock);
      chk(36'(q.size()), 36'h0);
      finish_test();
   end
endmodule // psb_sram_tb_top
`default_nettype wire
